// ===== ptf_pkg.sv
package ptf_pkg;
    // status word bit positions
    localparam int SR_T1_BIT = 15;
    localparam int SR_T0_BIT = 14;
    localparam int SR_S_BIT = 13;
    // trace mode encodings, upper bit first
    localparam logic [1:0] TRACE_OFF = 2'h0;
    localparam logic [1:0] TRACE_FLOW = 2'h1;
    localparam logic [1:0] TRACE_ALL = 2'h2;
    localparam logic [1:0] TRACE_RSVD = 2'h3;
    // vector numbers
    localparam logic [7:0] VEC_PRIV = 8'h08;
    localparam logic [7:0] VEC_TRACE = 8'h09;
    localparam logic [7:0] VEC_FORMAT = 8'h0E;
    // version word sits 54 bytes above the frame pointer
    localparam logic [31:0] FRAME_VERSION_OFFS = 32'h0000_0036;
    // accepted frame format codes, one bit per code
    localparam logic [15:0] FMT_VALID_MASK = 16'h0E07;
    localparam logic [3:0] FMT_LONG_FAULT = 4'hB;
    // module descriptor fields accepted by call and return
    localparam logic [2:0] MOD_OPT_OK = 3'h0;
    localparam logic [4:0] MOD_TYPE_OK = 5'h00;
    // values after reset
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_SR = 16'h0000;
    localparam logic [7:0] RST_VEC = 8'h00;
    // which instruction asks for a format check
    typedef enum logic [1:0]
    {
        FK_RTE = 2'b00,
        FK_MOD = 2'b01,
        FK_CPLOAD = 2'b10,
        FK_NONE = 2'b11
    } ptf_fmt_kind_t;
    // instruction tracking states
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_SUSP = 2'b10,
        ST_FORCED = 2'b11
    } ptf_state_t;
endpackage : ptf_pkg

// ===== ptf_exc_unit.sv
// Functional notes
// [RULE1] user-level privileged instruction raises privilege violation
// [RULE2] coprocessor privilege check at user level violates
// [RULE3] violation before execution: supervisor, trace off, vector 8
// [RULE4] violation stacks first word address of instruction
// [RULE5] trace bits: off, flow, all, reserved
// [RULE6] trace bits at instruction start decide trace
// [RULE7] flow mode traces branches, traps, returns, status writes
// [RULE8] breakpoint traced only if replacement changes flow
// [RULE9] suspended traced instruction defers trace until completion
// [RULE10] trace taken before pending interrupt
// [RULE11] forced exception processed before trace
// [RULE12] illegal instructions never traced
// [RULE13] trace after completion: vector 9, next address
// [RULE14] traced stop takes trace, never stops
// [RULE15] return checks format code and long-frame version
// [RULE16] module call/return checks fields and access rights
// [RULE17] coprocessor flags unknown state frame format
// [RULE18] format error: short frame, vector 14, this address
// [RULE19] emulation handler should emulate trace itself
// [RULE20] vector offset is number times four plus base
module ptf_exc_unit
#(
    parameter logic [7:0] CORE_VERSION = 8'h5A // arbitrary value
)
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_insn_start,
    input wire logic [31:0] i_insn_pc,
    input wire logic [15:0] i_status_word,
    input wire logic i_insn_priv,
    input wire logic i_cp_priv_req,
    input wire logic i_insn_illegal,
    input wire logic i_insn_flow,
    input wire logic i_insn_sr_write,
    input wire logic i_insn_breakpoint_insn,
    input wire logic i_breakpoint_insn_repl_flow,
    input wire logic i_insn_stop,
    input wire logic i_insn_resume,
    input wire logic i_insn_suspend,
    input wire logic i_insn_done,
    input wire logic [31:0] i_next_pc,
    input wire logic i_insn_forced,
    input wire logic i_forced_done,
    input wire logic i_fmt_check,
    input wire ptf_pkg::ptf_fmt_kind_t i_fmt_kind,
    input wire logic [3:0] i_frame_fmt,
    input wire logic [7:0] i_frame_version,
    input wire logic [2:0] i_mod_option,
    input wire logic [4:0] i_mod_type,
    input wire logic i_mmu_access_bad,
    input wire logic i_cp_fmt_err,
    input wire logic [31:0] i_frame_sp,
    input wire logic [31:0] i_vbr,
    output logic o_exc_take,
    output logic [7:0] o_exc_vector,
    output logic [9:0] o_vec_offset,
    output logic [31:0] o_vec_addr,
    output logic [31:0] o_stack_pc,
    output logic [15:0] o_stack_sr,
    output logic [15:0] o_new_sr,
    output logic o_short_frame,
    output logic o_insn_abort,
    output logic o_stop_enter,
    output logic o_irq_hold,
    output logic [1:0] o_trace_mode,
    output logic [31:0] o_version_addr
);
    import ptf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // trace mode field of a status word
    function automatic logic [1:0] trace_mode(input logic [15:0] sr);
        trace_mode = {sr[SR_T1_BIT], sr[SR_T0_BIT]}; // RULE5
    endfunction : trace_mode

    // status word after any of our exceptions: supervisor, trace off
    function automatic logic [15:0] exc_sr(input logic [15:0] sr);
        logic [15:0] r;
        r = sr;
        r[SR_S_BIT] = 1'b1;
        r[SR_T1_BIT] = 1'b0;
        r[SR_T0_BIT] = 1'b0;
        exc_sr = r;
    endfunction : exc_sr

    ////////////////////////////////////////////////////////////////////////
    // state

    ptf_state_t state_q, state_d; // instruction tracking
    logic arm_q, arm_d; // trace owed at completion
    logic stop_q, stop_d; // running instruction is a stop
    logic [31:0] pc_q, pc_d; // first word address of running insn
    logic take_d; // exception issued this cycle
    logic [7:0] vec_d;
    logic [31:0] spc_d;
    logic [15:0] ssr_d;
    logic short_d, abort_d, stopen_d;
    logic user_lvl; // processor at user level
    logic priv_viol; // privilege violation at start
    logic trace_want; // start-time trace decision
    logic fmt_ok; // format check verdict

    assign user_lvl = ~i_status_word[SR_S_BIT];
    assign o_trace_mode = trace_mode(i_status_word);
    assign o_version_addr = i_frame_sp + FRAME_VERSION_OFFS; // RULE15
    // interrupts wait while a trace is still owed
    assign o_irq_hold = arm_q; // RULE10

    ////////////////////////////////////////////////////////////////////////
    // start-of-instruction decode

    always_comb
    begin
        // privileged op or coprocessor check, only at user level
        priv_viol = user_lvl & (i_insn_priv | i_cp_priv_req); // RULE1 RULE2
        // decision uses the bits present as execution begins
        case (trace_mode(i_status_word)) // RULE6
            TRACE_ALL:
                trace_want = 1'b1;
            TRACE_FLOW:
                // sequential instructions are not traced
                trace_want = i_insn_flow | i_insn_sr_write // RULE7
                    | (i_insn_breakpoint_insn & i_breakpoint_insn_repl_flow); // RULE8
            default:
                // off, and reserved treated as off
                trace_want = 1'b0;
        endcase
        // illegal words are never executed, so never traced
        if (i_insn_illegal) // RULE12
        begin
            trace_want = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // format checks for return, module call/return, state load

    always_comb
    begin
        case (i_fmt_kind)
            FK_RTE:
                // code must be known; long fault also needs our version
                fmt_ok = FMT_VALID_MASK[i_frame_fmt] // RULE15
                    & ((i_frame_fmt != FMT_LONG_FAULT)
                    | (i_frame_version == CORE_VERSION));
            FK_MOD:
                fmt_ok = (i_mod_option == MOD_OPT_OK) // RULE16
                    & (i_mod_type == MOD_TYPE_OK) & ~i_mmu_access_bad;
            FK_CPLOAD:
                // coprocessor does the judging here
                fmt_ok = ~i_cp_fmt_err; // RULE17
            default:
                fmt_ok = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing and exception issue

    always_comb
    begin
        state_d = state_q;
        arm_d = arm_q;
        stop_d = stop_q;
        pc_d = pc_q;
        take_d = 1'b0;
        vec_d = VEC_PRIV;
        spc_d = pc_q;
        ssr_d = i_status_word;
        short_d = 1'b0;
        abort_d = 1'b0;
        stopen_d = 1'b0;
        case (state_q)
            ST_IDLE, ST_SUSP:
                if (i_insn_start)
                begin
                    pc_d = i_insn_pc;
                    if (priv_viol)
                    begin
                        // nothing executes; stack the offending address
                        take_d = 1'b1; // RULE3
                        abort_d = 1'b1;
                        spc_d = i_insn_pc; // RULE4
                        arm_d = 1'b0;
                        state_d = ST_IDLE;
                    end
                    else if (state_q == ST_SUSP && i_insn_resume)
                    begin
                        // keep the trace owed from the first attempt
                        state_d = ST_EXEC; // RULE9
                    end
                    else
                    begin
                        arm_d = trace_want;
                        stop_d = i_insn_stop;
                        state_d = ST_EXEC;
                    end
                end
            ST_EXEC:
                if (i_fmt_check && !fmt_ok)
                begin
                    // short frame, pc of the detecting instruction
                    take_d = 1'b1; // RULE18
                    vec_d = VEC_FORMAT;
                    short_d = 1'b1;
                    abort_d = 1'b1;
                    arm_d = 1'b0;
                    state_d = ST_IDLE;
                end
                else if (i_insn_suspend)
                begin
                    // bus or address fault: trace waits for the rerun
                    state_d = ST_SUSP; // RULE9
                end
                else if (i_insn_done)
                begin
                    // a traced stop loads the word but never halts
                    stopen_d = stop_q & ~arm_q; // RULE14
                    if (arm_q && i_insn_forced)
                    begin
                        // forced exception goes first
                        state_d = ST_FORCED; // RULE11
                    end
                    else if (arm_q)
                    begin
                        take_d = 1'b1; // RULE13
                        vec_d = VEC_TRACE;
                        spc_d = i_next_pc;
                        arm_d = 1'b0;
                        state_d = ST_IDLE;
                    end
                    else
                    begin
                        state_d = ST_IDLE;
                    end
                end
            ST_FORCED:
                if (i_forced_done)
                begin
                    // trace belongs to the forcing instruction
                    take_d = 1'b1; // RULE11 RULE13
                    vec_d = VEC_TRACE;
                    spc_d = i_next_pc;
                    arm_d = 1'b0;
                    state_d = ST_IDLE;
                end
            default:
                state_d = ST_IDLE;
        endcase
    end

    // registers only; exception outputs are flops so the core sees stable data, while o_trace_mode and o_version_addr are combinational
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_q <= ST_IDLE;
            arm_q <= 1'b0;
            stop_q <= 1'b0;
            pc_q <= RST_WORD;
            o_exc_take <= 1'b0;
            o_exc_vector <= RST_VEC;
            o_vec_offset <= 10'h000;
            o_vec_addr <= RST_WORD;
            o_stack_pc <= RST_WORD;
            o_stack_sr <= RST_SR;
            o_new_sr <= RST_SR;
            o_short_frame <= 1'b0;
            o_insn_abort <= 1'b0;
            o_stop_enter <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            arm_q <= arm_d;
            stop_q <= stop_d;
            pc_q <= pc_d;
            o_exc_take <= take_d;
            o_insn_abort <= abort_d;
            o_stop_enter <= stopen_d;
            if (take_d)
            begin
                o_exc_vector <= vec_d;
                o_vec_offset <= {vec_d, 2'b00}; // RULE20
                o_vec_addr <= i_vbr + {22'h000000, vec_d, 2'b00}; // RULE20
                o_stack_pc <= spc_d;
                o_stack_sr <= ssr_d;
                o_new_sr <= exc_sr(ssr_d); // RULE3 RULE13
                o_short_frame <= short_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_traced_done;
        state_q == ST_EXEC && arm_q && i_insn_done && !i_insn_forced
            && !(i_fmt_check && !fmt_ok) && !i_insn_suspend;
    endsequence

    a_priv_vector: assert property ( // RULE1
        (state_q != ST_EXEC && state_q != ST_FORCED && i_insn_start
            && user_lvl && i_insn_priv)
        |=> o_exc_take && o_exc_vector == 8'h08 && o_insn_abort)
        else $error("privileged op at user level not trapped");
    a_priv_stack_pc: assert property ( // RULE4
        (state_q == ST_IDLE && i_insn_start && priv_viol)
        |=> o_stack_pc == $past(i_insn_pc))
        else $error("privilege frame pc wrong");
    a_exc_new_sr: assert property ( // RULE3
        o_exc_take |-> o_new_sr[SR_S_BIT] && !o_new_sr[SR_T1_BIT]
            && !o_new_sr[SR_T0_BIT])
        else $error("exception status word not supervisor untraced");
    a_trace_issue: assert property ( // RULE13
        s_traced_done |=> o_exc_take && o_exc_vector == 8'h09
            && o_stack_pc == $past(i_next_pc))
        else $error("trace not issued after traced instruction");
    a_no_trace_off: assert property ( // RULE5
        (state_q == ST_IDLE && i_insn_start && !priv_viol
            && trace_mode(i_status_word) == 2'b00) |=> !arm_q)
        else $error("trace armed with tracing off");
    a_illegal_untraced: assert property ( // RULE12
        (state_q == ST_IDLE && i_insn_start && i_insn_illegal) |=> !arm_q)
        else $error("illegal instruction armed a trace");
    a_susp_keeps: assert property ( // RULE9
        (state_q == ST_EXEC && arm_q && i_insn_suspend
            && !(i_fmt_check && !fmt_ok))
        |=> arm_q && !o_exc_take && state_q == ST_SUSP)
        else $error("suspension lost or fired the trace");
    a_forced_first: assert property ( // RULE11
        (state_q == ST_FORCED && !i_forced_done) |=> !o_exc_take)
        else $error("trace taken before forced exception done");
    a_irq_held: assert property ( // RULE10
        s_traced_done |-> o_irq_hold ##1 o_exc_take)
        else $error("interrupt not held for owed trace");
    a_traced_stop: assert property ( // RULE14
        (state_q == ST_EXEC && stop_q && arm_q && i_insn_done)
        |=> !o_stop_enter)
        else $error("traced stop entered stopped state");
    a_fmt_error: assert property ( // RULE18
        (state_q == ST_EXEC && i_fmt_check && !fmt_ok)
        |=> o_exc_take && o_exc_vector == 8'h0E && o_short_frame
            && o_stack_pc == pc_q)
        else $error("format error not raised correctly");
    a_vec_offset: assert property ( // RULE20
        o_exc_take |-> o_vec_addr == i_vbr + {22'h000000, o_vec_offset}
            || $changed(i_vbr))
        else $error("vector address not base plus offset");
endmodule : ptf_exc_unit

// ===== ptf_far_model.sv
module ptf_far_model
#(
    parameter logic [3:0] CP_FMT_OK = 4'h1 // the one state frame it knows
)
(
    input wire logic i_cp_want,
    input wire logic i_rights_bad,
    input wire logic i_fmt_check,
    input wire ptf_pkg::ptf_fmt_kind_t i_fmt_kind,
    input wire logic [3:0] i_frame_fmt,
    output logic o_cp_priv_req,
    output logic o_cp_fmt_err,
    output logic o_mmu_access_bad
);
    import ptf_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // coprocessor asks a privilege check when the bench commands it
    assign o_cp_priv_req = i_cp_want;
    // unknown frame format rejected; only state loads reach the coprocessor
    assign o_cp_fmt_err = i_fmt_check && (i_fmt_kind == FK_CPLOAD)
        && (i_frame_fmt != CP_FMT_OK);
    // mmu veto only means something on module call and return
    assign o_mmu_access_bad = i_rights_bad && (i_fmt_kind == FK_MOD);
endmodule : ptf_far_model

// ===== ptf_exc_unit_test.sv
`define CHK(nm, ex, gt) \
    begin \
        tests_run++; \
        if ((gt) !== (ex)) \
        begin \
            $display("ERROR %s expected %h seen %h", nm, ex, gt); \
            fail_count++; \
        end \
    end

module ptf_exc_unit_test import ptf_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////////////
    // decode flags: priv, illegal, flow, sr write, breakpoint_insn, repl, stop
    localparam logic [6:0] F_PRIV = 7'h40;
    localparam logic [6:0] F_ILL = 7'h20;
    localparam logic [6:0] F_STOP = 7'h01;
    // flow-mode table: plain, flow, sr write, breakpoint_insn+flow repl, bare breakpoint_insn
    localparam logic [6:0] FL [5] = '{7'h00, 7'h10, 7'h08, 7'h06, 7'h04};
    localparam logic [4:0] FX = 5'h0E; // which table rows must trace
    localparam logic [31:0] PC = 32'h0000_4000;
    localparam logic [31:0] NPC = 32'h0000_4006;
    localparam logic [7:0] VER = 8'h5A; // arbitrary value
    logic i_clk, i_rst_b, i_insn_start, i_insn_priv, i_insn_illegal;
    logic i_insn_flow, i_insn_sr_write, i_insn_breakpoint_insn, i_breakpoint_insn_repl_flow;
    logic i_insn_stop, i_insn_resume, i_insn_suspend, i_insn_done;
    logic i_insn_forced, i_forced_done, i_fmt_check, i_mmu_access_bad;
    logic i_cp_priv_req, i_cp_fmt_err, cp_want, rights_bad, seen;
    logic [31:0] i_insn_pc, i_next_pc, i_frame_sp, i_vbr;
    logic [15:0] i_status_word;
    logic [3:0] i_frame_fmt;
    logic [7:0] i_frame_version;
    logic [2:0] i_mod_option;
    logic [4:0] i_mod_type;
    ptf_fmt_kind_t i_fmt_kind;
    logic o_exc_take, o_short_frame, o_insn_abort, o_stop_enter, o_irq_hold;
    logic [7:0] o_exc_vector;
    logic [9:0] o_vec_offset;
    logic [31:0] o_vec_addr, o_stack_pc, o_version_addr;
    logic [15:0] o_stack_sr, o_new_sr;
    logic [1:0] o_trace_mode;
    int fail_count, tests_run;

    ptf_exc_unit #(.CORE_VERSION(VER)) ptf_exc_unit_inst (.*);
    ptf_far_model ptf_far_model_inst (.i_cp_want(cp_want),
        .i_rights_bad(rights_bad), .i_fmt_check(i_fmt_check),
        .i_fmt_kind(i_fmt_kind), .i_frame_fmt(i_frame_fmt),
        .o_cp_priv_req(i_cp_priv_req), .o_cp_fmt_err(i_cp_fmt_err),
        .o_mmu_access_bad(i_mmu_access_bad));

    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////
    // verdict and stop
    task end_of_test;
        if (fail_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // one-cycle start pulse with decode flags, driven at falling edge
    task go(input logic [15:0] sr, input logic [6:0] f);
        i_status_word = sr;
        {i_insn_priv, i_insn_illegal, i_insn_flow, i_insn_sr_write,
            i_insn_breakpoint_insn, i_breakpoint_insn_repl_flow, i_insn_stop} = f;
        i_insn_start = 1'b1;
        @(negedge i_clk);
        // looked at a full cycle later, once the decode has settled
        `CHK("trace_mode", sr[15:14], o_trace_mode)
        i_insn_start = 1'b0;
    endtask : go

    // completion pulse, optionally with a forced exception
    task fin(input logic forced);
        i_insn_done = 1'b1;
        i_insn_forced = forced;
        @(negedge i_clk);
        i_insn_done = 1'b0;
        i_insn_forced = 1'b0;
    endtask : fin

    // no exception may be taken for n cycles
    task none(input int n);
        repeat (n)
        begin
            `CHK("quiet take", 1'b0, o_exc_take)
            @(negedge i_clk);
        end
    endtask : none

    // bounded wait for a take, then every stacked field
    task take(input logic [7:0] v, input logic [31:0] pc,
        input logic [15:0] s, input logic ab, input logic sf);
        int n;
        n = 0;
        while (o_exc_take !== 1'b1 && n < 4)
        begin
            @(negedge i_clk);
            n++;
        end
        `CHK("take", 1'b1, o_exc_take)
        if (o_exc_take !== 1'b1)
            end_of_test;
        else
        begin
            `CHK("vector", v, o_exc_vector)
            `CHK("offset", {v, 2'b00}, o_vec_offset)
            `CHK("vec_addr", i_vbr + {22'h0, v, 2'b00}, o_vec_addr)
            `CHK("stack_pc", pc, o_stack_pc)
            `CHK("stack_sr", s, o_stack_sr)
            `CHK("new_sr", (s & 16'h3FFF) | 16'h2000, o_new_sr)
            `CHK("abort", ab, o_insn_abort)
            `CHK("short", sf, o_short_frame)
            `CHK("stop_enter", 1'b0, o_stop_enter)
            @(negedge i_clk);
        end
    endtask : take

    // one format check case; ot is option and type together
    task fcase(input ptf_fmt_kind_t k, input logic [3:0] ff,
        input logic [7:0] ver, input logic [7:0] ot, input logic mb,
        input logic bad);
        go(16'h2000, 7'h00);
        {i_mod_option, i_mod_type} = ot;
        i_fmt_kind = k;
        i_frame_fmt = ff;
        i_frame_version = ver;
        rights_bad = mb;
        i_fmt_check = 1'b1;
        @(negedge i_clk);
        i_fmt_check = 1'b0;
        rights_bad = 1'b0;
        i_fmt_kind = FK_NONE;
        if (bad)
            take(VEC_FORMAT, PC, 16'h2000, 1'b1, 1'b1);
        else
        begin
            none(2);
            fin(1'b0);
            none(2);
        end
    endtask : fcase

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {i_clk, i_rst_b, i_insn_start, i_insn_priv, i_insn_illegal} = '0;
        {i_insn_flow, i_insn_sr_write, i_insn_breakpoint_insn, i_breakpoint_insn_repl_flow} = '0;
        {i_insn_stop, i_insn_resume, i_insn_suspend, i_insn_done} = '0;
        {i_insn_forced, i_forced_done, i_fmt_check, cp_want} = '0;
        {rights_bad, i_frame_fmt, i_frame_version, i_mod_option} = '0;
        i_mod_type = 5'h00;
        i_fmt_kind = FK_NONE;
        i_insn_pc = PC;
        i_next_pc = NPC;
        i_frame_sp = 32'h0000_8000;
        i_vbr = 32'h0000_1000;
        i_status_word = 16'h2000;
        fail_count = 0;
        tests_run = 0;
        repeat (12) @(negedge i_clk);
        i_rst_b = 1'b1;
        `CHK("version_addr", 32'h0000_8036, o_version_addr)
        // user-level privileged word, trace bits must clear
        go(16'h8000, F_PRIV);
        take(VEC_PRIV, PC, 16'h8000, 1'b1, 1'b0);
        // an emulation handler reads the stacked trace bits from here
        `CHK("handler_trace", TRACE_ALL, o_stack_sr[15:14])
        cp_want = 1'b1;
        go(16'h0000, 7'h00);
        cp_want = 1'b0;
        take(VEC_PRIV, PC, 16'h0000, 1'b1, 1'b0);
        go(16'h2000, F_PRIV);
        fin(1'b0);
        none(3);
        // trace decided at start even if status drops tracing meanwhile
        go(16'h8000, 7'h00);
        `CHK("irq_hold", 1'b1, o_irq_hold)
        i_status_word = 16'h2000;
        fin(1'b0);
        take(VEC_TRACE, NPC, 16'h2000, 1'b0, 1'b0);
        `CHK("irq_hold", 1'b0, o_irq_hold)
        for (int i = 0; i < 5; i++)
        begin
            go(16'h4000, FL[i]);
            fin(1'b0);
            if (FX[i])
                take(VEC_TRACE, NPC, 16'h4000, 1'b0, 1'b0);
            else
                none(3);
        end
        // reserved mode behaves as off
        for (int i = 0; i < 2; i++)
        begin
            go(i ? 16'hC000 : 16'h0000, FL[1] | FL[2]);
            fin(1'b0);
            none(3);
        end
        go(16'h8000, F_ILL);
        none(2);
        fin(1'b0);
        none(3);
        // suspended by a bus fault, traced only after resume completes
        go(16'h8000, 7'h00);
        i_insn_suspend = 1'b1;
        @(negedge i_clk);
        i_insn_suspend = 1'b0;
        none(3);
        i_insn_resume = 1'b1;
        go(16'h2000, 7'h00);
        i_insn_resume = 1'b0;
        fin(1'b0);
        take(VEC_TRACE, NPC, 16'h2000, 1'b0, 1'b0);
        // forced exception goes before the owed trace
        go(16'h8000, 7'h00);
        fin(1'b1);
        none(3);
        `CHK("irq_hold", 1'b1, o_irq_hold)
        i_forced_done = 1'b1;
        @(negedge i_clk);
        i_forced_done = 1'b0;
        take(VEC_TRACE, NPC, 16'h8000, 1'b0, 1'b0);
        // stop: untraced stops, traced never does
        go(16'h2000, F_STOP | F_PRIV);
        fin(1'b0);
        seen = 1'b0;
        repeat (2)
        begin
            seen = seen | o_stop_enter;
            @(negedge i_clk);
        end
        `CHK("stop_enter", 1'b1, seen)
        // stop is privileged, so the traced one runs at supervisor level
        go(16'hA000, F_STOP | F_PRIV);
        i_status_word = 16'h2700;
        fin(1'b0);
        take(VEC_TRACE, NPC, 16'h2700, 1'b0, 1'b0);
        // format checks, good and bad
        fcase(FK_RTE, 4'h3, 8'h00, 8'h00, 1'b0, 1'b1);
        fcase(FK_RTE, 4'hB, 8'h00, 8'h00, 1'b0, 1'b1);
        fcase(FK_RTE, 4'hB, VER, 8'h00, 1'b0, 1'b0);
        fcase(FK_RTE, 4'h0, 8'h00, 8'h00, 1'b0, 1'b0);
        fcase(FK_MOD, 4'h0, 8'h00, 8'h20, 1'b0, 1'b1);
        fcase(FK_MOD, 4'h0, 8'h00, 8'h01, 1'b0, 1'b1);
        fcase(FK_MOD, 4'h0, 8'h00, 8'h00, 1'b1, 1'b1);
        fcase(FK_MOD, 4'h0, 8'h00, 8'h00, 1'b0, 1'b0);
        fcase(FK_CPLOAD, 4'h2, 8'h00, 8'h00, 1'b0, 1'b1);
        fcase(FK_CPLOAD, 4'h1, 8'h00, 8'h00, 1'b0, 1'b0);
        end_of_test;
    end
endmodule : ptf_exc_unit_test
